//--- logic/fsr_consts.vh
// constants for the flash suspend/resume sequencer
// assumes a 10 ns system clock; included by fsr_core.v only
`ifndef FSR_CONSTS_VH
`define FSR_CONSTS_VH

// command bytes
`define FSR_CMD_ERS_SUSPEND  8'h75
`define FSR_CMD_ERS_RESUME   8'h7a
`define FSR_CMD_PGM_SUSPEND  8'h85
`define FSR_CMD_PGM_RESUME   8'h8a
`define FSR_CMD_PARAM_READ   8'h5a

// suspend-timing parameter dword, bit 8 reserved and reads one
`define FSR_PARAM_DW12       32'h451883ec

// latency encodings carried in the dword
`define FSR_ERS_LAT_COUNT    5'h05
`define FSR_PGM_LAT_COUNT    5'h04
`define FSR_PGM_LAT_UNITS    2'h2
`define FSR_RES_INTERVAL_CNT 4'h1

// timing: figures in ns, counts in system clocks
`define FSR_CLK_NS           10
`define FSR_ERS_SUSP_LAT_NS  48000
`define FSR_PGM_SUSP_LAT_NS  40000
// 48 us and 40 us expressed as counts of the 10 ns clock
`define FSR_ERS_SUSP_CYC     13'h12c0
`define FSR_PGM_SUSP_CYC     13'h0fa0

// fields and widths
`define FSR_CNT_W            13
`define FSR_BITCNT_W         6

// reset values
`define FSR_CNT_RST          13'h0000
`define FSR_BYTE_RST         8'h00

`endif

//--- logic/fsr_core.v
// suspend/resume sequencer of the serial flash: spi command decode,
// suspend latency timing and the suspend-timing parameter read
// assumes sck, cs_n and mosi are asynchronous pins (spi mode 0) and that
// erase_active / program_active come from the array engine on clk
`timescale 1ns/100ps
`include "fsr_consts.vh"

// Function
// - erase suspended state reached no later than 48 us after 75h
// - program suspended state reached no later than 40 us after 85h
// - byte 75h decodes as erase suspend
// - byte 7Ah decodes as erase resume
// - parameter read returns dword 45_18_83_EC, bit 8 set
// - byte 85h decodes as program suspend
// - byte 8Ah decodes as program resume
module fsr_core #(
  parameter [`FSR_CNT_W-1:0] ERS_SUSP_CYC = `FSR_ERS_SUSP_CYC
) (
  // system
  input  wire clk,
  input  wire nrst,
  // spi link
  input  wire sck,
  input  wire cs_n,
  input  wire mosi,
  output reg  miso,
  output reg  miso_oe,
  // array engine
  input  wire erase_active,
  input  wire program_active,
  output reg  erase_hold,
  output reg  program_hold,
  // status
  output reg  erase_suspended,
  output reg  program_suspended
);

  // sequencer states: pending waits out the latency, suspended waits for resume
  localparam [2:0] ST_IDLE     = 3'h0;
  localparam [2:0] ST_ERS_PEND = 3'h1;
  localparam [2:0] ST_ERS_SUSP = 3'h2;
  localparam [2:0] ST_PGM_PEND = 3'h3;
  localparam [2:0] ST_PGM_SUSP = 3'h4;

  // program latency is fixed; only the erase one is a parameter for short benches
  localparam [`FSR_CNT_W-1:0] PGM_SUSP_CYC = `FSR_PGM_SUSP_CYC;
  localparam [31:0]           PARAM_DW     = `FSR_PARAM_DW12;

  // one decoded command strobe matched against an opcode
  function fsr_cmd_hit;
    input       valid;
    input [7:0] got;
    input [7:0] want;
    begin
      fsr_cmd_hit = valid && (got == want);
    end
  endfunction

  // the dword leaves its low byte first, each byte msb first, so the
  // shift register is loaded with the bytes in reverse order
  function [31:0] fsr_wire_order;
    input [31:0] dw;
    begin
      fsr_wire_order = {dw[7:0], dw[15:8], dw[23:16], dw[31:24]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg  [2:0]              sck_s;
  reg  [1:0]              cs_s;
  reg  [1:0]              mosi_s;
  reg                     cs_d;
  reg  [7:0]              shift_in;
  reg  [`FSR_BITCNT_W-1:0] bit_cnt;
  reg  [31:0]             shift_out;
  reg                     reading;
  reg  [7:0]              cmd;
  reg                     cmd_valid;
  reg  [2:0]              state;
  reg  [`FSR_CNT_W-1:0]   lat_cnt;

  wire sck_rise = sck_s[1] & ~sck_s[2];
  wire sck_fall = ~sck_s[1] & sck_s[2];
  wire cs_low   = ~cs_s[1];
  wire cs_rise  = cs_s[1] & ~cs_d;

  // only the second stage and later taps feed edge logic
  always @(posedge clk) begin
    if (!nrst) begin
      sck_s  <= 3'h0;
      cs_s   <= 2'h3;
      mosi_s <= 2'h0;
      cs_d   <= 1'b1;
    end else begin
      sck_s  <= {sck_s[1:0], sck};
      cs_s   <= {cs_s[0], cs_n};
      mosi_s <= {mosi_s[0], mosi};
      cs_d   <= cs_s[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command shifter: msb first, sampled on sck rise
  // a command byte counts only when cs rises after exactly eight bits,
  // so partial or longer frames never trigger a suspend or resume
  always @(posedge clk) begin
    if (!nrst) begin
      shift_in  <= `FSR_BYTE_RST;
      bit_cnt   <= {`FSR_BITCNT_W{1'b0}};
      cmd       <= `FSR_BYTE_RST;
      cmd_valid <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      if (!cs_low) begin
        bit_cnt <= {`FSR_BITCNT_W{1'b0}};
        if (cs_rise && bit_cnt == 6'd8) begin
          cmd       <= shift_in;
          cmd_valid <= 1'b1;
        end
      end else if (sck_rise) begin
        shift_in <= {shift_in[6:0], mosi_s[1]};
        if (bit_cnt != {`FSR_BITCNT_W{1'b1}})
          bit_cnt <= bit_cnt + 6'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // parameter read: after opcode 5ah the dword leaves low byte first,
  // each byte msb first, shifted on sck fall
  always @(posedge clk) begin
    if (!nrst) begin
      shift_out <= 32'h00000000;
      reading   <= 1'b0;
      miso      <= 1'b0;
      miso_oe   <= 1'b0;
    end else begin
      miso_oe <= cs_low & reading;
      if (!cs_low) begin
        reading <= 1'b0;
      end else if (sck_rise && bit_cnt == 6'd7 &&
                   {shift_in[6:0], mosi_s[1]} == `FSR_CMD_PARAM_READ) begin
        reading   <= 1'b1;
        shift_out <= fsr_wire_order(PARAM_DW);
      end else if (sck_fall && reading) begin
        miso      <= shift_out[31];
        shift_out <= {shift_out[30:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // suspend sequencer
  // the hold goes out at once; the suspended flag waits the full latency
  // so the engine always has its worst-case time to reach a safe point
  always @(posedge clk) begin
    if (!nrst) begin
      state             <= ST_IDLE;
      lat_cnt           <= `FSR_CNT_RST;
      erase_hold        <= 1'b0;
      program_hold      <= 1'b0;
      erase_suspended   <= 1'b0;
      program_suspended <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (fsr_cmd_hit(cmd_valid, cmd, `FSR_CMD_ERS_SUSPEND) && erase_active) begin
            state      <= ST_ERS_PEND;
            lat_cnt    <= ERS_SUSP_CYC - 13'h0001;
            erase_hold <= 1'b1;
          end else if (fsr_cmd_hit(cmd_valid, cmd, `FSR_CMD_PGM_SUSPEND) && program_active) begin
            state        <= ST_PGM_PEND;
            lat_cnt      <= PGM_SUSP_CYC - 13'h0001;
            program_hold <= 1'b1;
          end
        end
        ST_ERS_PEND: begin
          if (lat_cnt == `FSR_CNT_RST) begin
            state           <= ST_ERS_SUSP;
            erase_suspended <= 1'b1;
          end else begin
            lat_cnt <= lat_cnt - 13'd1;
          end
        end
        ST_ERS_SUSP: begin
          if (fsr_cmd_hit(cmd_valid, cmd, `FSR_CMD_ERS_RESUME)) begin
            state           <= ST_IDLE;
            erase_hold      <= 1'b0;
            erase_suspended <= 1'b0;
          end
        end
        ST_PGM_PEND: begin
          if (lat_cnt == `FSR_CNT_RST) begin
            state             <= ST_PGM_SUSP;
            program_suspended <= 1'b1;
          end else begin
            lat_cnt <= lat_cnt - 13'd1;
          end
        end
        ST_PGM_SUSP: begin
          if (fsr_cmd_hit(cmd_valid, cmd, `FSR_CMD_PGM_RESUME)) begin
            state             <= ST_IDLE;
            program_hold      <= 1'b0;
            program_suspended <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

//--- tb/fsr_sva.sv
// checker for the suspend/resume status outputs of fsr_core
// assumes it is bound to every fsr_core instance
`timescale 1ns/100ps
module fsr_sva #(parameter ERS_SUSP_CYC = 4800) (
  // system
  input wire clk,
  input wire nrst,
  // array engine and status
  input wire erase_active,
  input wire program_active,
  input wire erase_hold,
  input wire program_hold,
  input wire erase_suspended,
  input wire program_suspended
);
  reg [12:0] cnt;
  // cycles spent waiting for a suspend to land, zero otherwise
  always @(posedge clk) begin
    if (!nrst || !((erase_hold && !erase_suspended) || (program_hold && !program_suspended)))
      cnt <= 13'h0000;
    else
      cnt <= cnt + 13'h0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ers_latency_a: assert property (erase_hold |-> cnt <= ERS_SUSP_CYC)
    else $error("erase suspend late");
  pgm_latency_a: assert property (program_hold |-> cnt <= 4000)
    else $error("program suspend late");
  ers_state_a: assert property (erase_suspended |-> erase_hold)
    else $error("erase suspended without hold");
  pgm_state_a: assert property (program_suspended |-> program_hold)
    else $error("program suspended without hold");
  ers_accept_a: assert property ($rose(erase_hold) |-> $past(erase_active) && !program_hold)
    else $error("erase hold without running erase");
  pgm_accept_a: assert property ($rose(program_hold) |-> $past(program_active) && !erase_hold)
    else $error("program hold without running program");
  ers_release_a: assert property ($fell(erase_hold) |-> $past(erase_suspended) && $fell(erase_suspended))
    else $error("erase released badly");
  pgm_release_a: assert property ($fell(program_hold) |-> $past(program_suspended) && $fell(program_suspended))
    else $error("program released badly");
endmodule
bind fsr_core fsr_sva #(.ERS_SUSP_CYC(ERS_SUSP_CYC)) fsr_sva_i (.clk, .nrst, .erase_active, .program_active,
  .erase_hold, .program_hold, .erase_suspended, .program_suspended);

//--- tb/fsr_host.sv
// host side of the spi link: sends one frame, reads miso back
// assumes clk from the bench; sck runs only inside frames
`timescale 1ns/100ps
module fsr_host (
  input  wire clk,
  input  wire miso,
  output reg  sck,
  output reg  cs_n,
  output reg  mosi
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // eight system clocks make half of the 160 ns link period
  task half;
    repeat (8) @(negedge clk);
  endtask
  // opcode msb first, then nrd bits shifted in from miso
  task frame(input [7:0] op, input integer nrd, output [31:0] rd);
    integer i;
    begin
      rd = 32'h00000000;
      cs_n = 1'b0;
      for (i = 0; i < 8 + nrd; i = i + 1) begin
        mosi = (i < 8) ? op[7 - i] : ~mosi; // unused line keeps toggling
        half;
        sck = 1'b1;
        if (i >= 8) rd = {rd[30:0], miso};
        half;
        sck = 1'b0;
      end
      half;
      cs_n = 1'b1;
      mosi = ~mosi;
      half;
    end
  endtask
endmodule

//--- tb/fsr_core_bench.sv
// self-checking bench for fsr_core with the host model
// assumes a short erase latency parameter of 20 clocks
`timescale 1ns/100ps
module fsr_core_bench;
  reg clk, nrst, erase_active, program_active;
  wire sck, cs_n, mosi, miso, miso_oe, erase_hold, program_hold, erase_suspended, program_suspended;
  wire [3:0] st = {program_suspended, erase_suspended, program_hold, erase_hold};
  // the host sees the inverse of miso whenever the device leaves it undriven
  wire miso_pin = miso_oe ? miso : ~miso;
  integer n_errors, checks_done, n, lat;
  reg [31:0] rd;
  fsr_core #(.ERS_SUSP_CYC(13'h0014)) fsr_core_i (.clk, .nrst, .sck, .cs_n, .mosi, .miso, .miso_oe,
    .erase_active, .program_active, .erase_hold, .program_hold, .erase_suspended, .program_suspended);
  fsr_host fsr_host_i (.clk, .miso(miso_pin), .sck, .cs_n, .mosi);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // latency from hold to suspended, frozen once suspended
  always @(negedge clk) begin
    if (!(erase_hold || program_hold)) lat <= 0;
    else if (!(erase_suspended || program_suspended)) lat <= lat + 1;
  end
  task conclude;
    begin
      if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // bounded wait for one status bit
  task wt(input integer k);
    begin
      n = 0;
      while (st[k] !== 1'b1) begin
        @(negedge clk);
        n = n + 1;
        if (n > 6000) begin
          n_errors = n_errors + 1;
          conclude;
        end
      end
    end
  endtask
  initial begin
    n_errors = 0;
    checks_done = 0;
    nrst = 1'b0;
    erase_active = 1'b0;
    program_active = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    check({erase_hold, program_hold, erase_suspended, program_suspended, miso_oe}, 32'h0);
    fsr_host_i.frame(8'h5a, 32, rd);
    check(rd, 32'hec831845);
    check(miso_oe, 32'h0);
    fsr_host_i.frame(8'h75, 0, rd);
    check(erase_hold, 32'h0);
    erase_active = 1'b1;
    program_active = 1'b1;
    fsr_host_i.frame(8'h75, 0, rd);
    wt(2);
    check(lat, 32'h14);
    check(program_hold, 32'h0);
    fsr_host_i.frame(8'h8a, 0, rd);
    check(erase_hold, 32'h1);
    fsr_host_i.frame(8'h7a, 0, rd);
    check({erase_hold, erase_suspended}, 32'h0);
    erase_active = 1'b0;
    repeat (12800) @(negedge clk);
    fsr_host_i.frame(8'h85, 0, rd);
    check(program_hold, 32'h1);
    fsr_host_i.frame(8'h8a, 0, rd);
    check(program_hold, 32'h1);
    wt(3);
    check(lat, 32'hfa0);
    fsr_host_i.frame(8'h8a, 0, rd);
    check({program_hold, program_suspended}, 32'h0);
    conclude;
  end
endmodule
